// ==== hw/dmrf_cal_invert.sv ====
// Lower byte calibration pattern inverter
`include "dmrf_params.svh"
module dmrf_cal_invert
	import dmrf_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       cal_req,
	input  wire logic [7:0] cal_pattern,
	input  wire logic       cal_dmi_in,
	input  wire logic [7:0] invert_mask,
	output dmrf_cal_s       cal_out
);
	dmrf_cal_s st;
	dmrf_cal_s next_st;

	always_comb begin
		next_st       = '0;
		next_st.valid = cal_req;
		if (cal_req) begin
			next_st.dq  = cal_pattern ^ invert_mask;
			// No bus inversion here: the mask line goes out as stored
			next_st.data_mask_inversion_line = cal_dmi_in;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cal_out = st;

	AST_CAL_INVERT: assert property (@(posedge core_clk) disable iff (rst)
		cal_req |=> cal_out.valid && cal_out.dq == ($past(cal_pattern) ^ $past(invert_mask)))
		else $error("calibration byte not inverted by mask");
	AST_CAL_DMI_TRUE: assert property (@(posedge core_clk) disable iff (rst)
		cal_req |=> cal_out.data_mask_inversion_line == $past(cal_dmi_in))
		else $error("mask line altered during calibration");
endmodule

// ==== hw/dmrf_params.svh ====
// Constants for the mode register group: addresses, reset values and codes
`ifndef DMRF_PARAMS_SVH
`define DMRF_PARAMS_SVH

`define DMRF_MA_TRAIN      6'h0d
`define DMRF_MA_DQREF      6'h0e
`define DMRF_MA_INVERT     6'h0f
`define DMRF_TRAIN_RST     8'h00
`define DMRF_DQREF_RST     8'h4d
`define DMRF_INVERT_RST    8'h55
`define DMRF_DQREF_MAX     6'h32
`define DMRF_REF_CODE_A    3'h1
`define DMRF_REF_CODE_B    3'h2
`define DMRF_REF_CODE_SUB  3'h3

`endif

// ==== hw/dmrf_pkg.sv ====
// Types shared by the mode register group
package dmrf_pkg;

	// Field order follows the operand bit order 7 down to 0
	typedef struct packed {
		logic operating_setpoint_bit;
		logic write_read_setpoint_bit;
		logic dm_dis;
		logic refresh_rate_option_bit;
		logic reference_current_bit;
		logic reference_output_bit;
		logic read_preamble_training_bit;
		logic command_bus_training_bit;
	} dmrf_train_s;

	typedef struct packed {
		logic       rsvd;
		logic       hi_range;
		logic [5:0] level;
	} dmrf_dqref_s;

	typedef struct packed {
		logic       mrw;
		logic       mrr;
		logic [5:0] addr;
		logic [7:0] op;
	} dmrf_cmd_s;

	typedef enum logic [1:0] {
		DMRF_DQ_IDLE = 2'b00,
		DMRF_DQ_MRR  = 2'b01,
		DMRF_DQ_CBT  = 2'b10,
		DMRF_DQ_VREF = 2'b11
	} dmrf_dq_src_e;

	typedef struct packed {
		dmrf_train_s            train;
		dmrf_dqref_s [1:0]      dqref;
		logic        [7:0]      invert;
		dmrf_dq_src_e           dq_src;
		logic        [15:0]     dq_data;
		logic        [2:0]      temp_report;
	} dmrf_state_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] dq;
		logic       data_mask_inversion_line;
	} dmrf_cal_s;

endpackage

// ==== hw/dmrf_top.sv ====
// Training control, DQ reference and lower invert mode registers
`include "dmrf_params.svh"
module dmrf_top
	import dmrf_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  dmrf_cmd_s       cmd,
	input  wire logic       cke,
	input  wire logic [5:0] ca,
	input  wire logic [6:0] ca_ref_fsp0,
	input  wire logic [6:0] ca_ref_fsp1,
	input  wire logic       feature_rro,
	input  wire logic [2:0] temp_raw,
	input  wire logic       cal_req,
	input  wire logic [7:0] cal_pattern,
	input  wire logic       cal_dmi_in,
	output logic      [15:0] dq_out,
	output logic            dq_oe,
	output dmrf_cal_s       cal_out,
	output logic            cbt_mode,
	output logic            preamble_training,
	output logic            vref_fast,
	output logic            data_mask_disabled,
	output logic            operating_setpoint_bit,
	output logic      [6:0] active_dq_ref,
	output logic      [2:0] temp_report
);
	dmrf_state_s st;
	dmrf_state_s next_st;
	logic        cmd_ok;
	logic        cbt_echo;
	dmrf_dqref_s rd_sel;
	dmrf_dqref_s op_sel;
	logic  [6:0] ca_ref_act;

	function automatic logic level_legal(input logic [5:0] lvl);
		level_legal = (lvl <= `DMRF_DQREF_MAX);
	endfunction

	function automatic logic [2:0] refresh_code(input logic [2:0] raw, input logic feat,
		input logic refresh_rate_option_bit);
		refresh_code = raw;
		if (feat && !refresh_rate_option_bit && (raw == `DMRF_REF_CODE_A || raw == `DMRF_REF_CODE_B)) begin
			refresh_code = `DMRF_REF_CODE_SUB;
		end
	endfunction

	// Bus training with CKE low owns the CA pins, so no command is decoded
	assign cbt_echo   = st.train.command_bus_training_bit && !cke;
	assign cmd_ok     = !cbt_echo;
	assign rd_sel     = st.dqref[st.train.write_read_setpoint_bit];
	assign op_sel     = st.dqref[st.train.operating_setpoint_bit];
	assign ca_ref_act = st.train.operating_setpoint_bit ? ca_ref_fsp1 : ca_ref_fsp0;

	always_comb begin
		next_st         = st;
		next_st.dq_src  = DMRF_DQ_IDLE;
		next_st.dq_data = '0;
		if (cmd.mrw && cmd_ok) begin
			unique case (cmd.addr)
				`DMRF_MA_TRAIN: begin
					next_st.train = cmd.op;
				end
				`DMRF_MA_DQREF: begin
					// Reserved level codes are dropped whole, range bit included
					if (level_legal(cmd.op[5:0])) begin
						next_st.dqref[st.train.write_read_setpoint_bit] = {1'b0, cmd.op[6:0]};
					end
				end
				`DMRF_MA_INVERT: begin
					next_st.invert = cmd.op;
				end
				default: begin
				end
			endcase
		end
		if (cbt_echo) begin
			next_st.dq_src  = DMRF_DQ_CBT;
			next_st.dq_data = {10'h000, ca};
		end else if (cmd.mrr) begin
			next_st.dq_src = DMRF_DQ_MRR;
			// Write-only registers answer with zeros
			if (cmd.addr == `DMRF_MA_DQREF) begin
				next_st.dq_data = {8'h00, 1'b0, rd_sel.hi_range, rd_sel.level};
			end
		end else if (st.train.reference_output_bit) begin
			next_st.dq_src  = DMRF_DQ_VREF;
			next_st.dq_data = {1'b0, ca_ref_act, 1'b0, op_sel.hi_range, op_sel.level};
		end
		next_st.temp_report = refresh_code(temp_raw, feature_rro, st.train.refresh_rate_option_bit);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st             <= '0;
			st.train       <= `DMRF_TRAIN_RST;
			st.dqref[0]    <= `DMRF_DQREF_RST;
			st.dqref[1]    <= `DMRF_DQREF_RST;
			st.invert      <= `DMRF_INVERT_RST;
			st.dq_src      <= DMRF_DQ_IDLE;
		end else begin
			st <= next_st;
		end
	end

	dmrf_cal_invert u_cal (
		.core_clk    (core_clk),
		.rst         (rst),
		.cal_req     (cal_req),
		.cal_pattern (cal_pattern),
		.cal_dmi_in  (cal_dmi_in),
		.invert_mask (st.invert),
		.cal_out     (cal_out)
	);

	assign dq_out             = st.dq_data;
	assign dq_oe              = (st.dq_src != DMRF_DQ_IDLE);
	assign cbt_mode           = st.train.command_bus_training_bit;
	assign preamble_training  = st.train.read_preamble_training_bit;
	assign vref_fast          = st.train.reference_current_bit;
	assign data_mask_disabled = st.train.dm_dis;
	assign operating_setpoint_bit             = st.train.operating_setpoint_bit;
	assign active_dq_ref      = {op_sel.hi_range, op_sel.level};
	assign temp_report        = st.temp_report;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_TRAIN_WRITE: assert property (cmd.mrw && cmd_ok && cmd.addr == `DMRF_MA_TRAIN
		|=> cbt_mode == $past(cmd.op[0]) && preamble_training == $past(cmd.op[1])
		&& vref_fast == $past(cmd.op[3]))
		else $error("training control write not applied");
	AST_CBT_ECHO: assert property (cbt_mode && !cke
		|=> dq_oe && dq_out == {10'h000, $past(ca)})
		else $error("bus training echo missing");
	AST_CBT_IGNORE: assert property (cbt_mode && !cke && cmd.mrw
		|=> st.invert == $past(st.invert) && st.dqref == $past(st.dqref) && cbt_mode)
		else $error("command taken during bus training");
	AST_VREF_OUT: assert property (st.train.reference_output_bit && cke && !cmd.mrr
		|=> dq_oe && dq_out[6:0] == $past(active_dq_ref))
		else $error("reference output wrong");
	AST_NO_FEATURE: assert property (!feature_rro
		|=> temp_report == $past(temp_raw))
		else $error("refresh report altered without feature");
	AST_RRO_SUB: assert property (feature_rro && !st.train.refresh_rate_option_bit
		&& (temp_raw == `DMRF_REF_CODE_A || temp_raw == `DMRF_REF_CODE_B)
		|=> temp_report == `DMRF_REF_CODE_SUB)
		else $error("refresh code not substituted");
	AST_MRR_DQREF: assert property (cmd.mrr && cmd_ok && cmd.addr == `DMRF_MA_DQREF
		|=> dq_oe && dq_out == {9'h000, $past(rd_sel.hi_range), $past(rd_sel.level)})
		else $error("reference read data wrong");
	AST_FSP_ISOLATE: assert property (cmd.mrw && cmd_ok && cmd.addr == `DMRF_MA_DQREF
		&& st.train.write_read_setpoint_bit != st.train.operating_setpoint_bit |=> $stable(active_dq_ref))
		else $error("inactive set point write disturbed operation");
	AST_RESERVED_CODE: assert property (cmd.mrw && cmd_ok && cmd.addr == `DMRF_MA_DQREF
		&& cmd.op[5:0] > `DMRF_DQREF_MAX |=> st.dqref == $past(st.dqref))
		else $error("reserved level code stored");
	AST_RESET_DEFAULTS: assert property ($past(rst) |-> st.invert == `DMRF_INVERT_RST
		&& st.dqref[0] == `DMRF_DQREF_RST && st.dqref[1] == `DMRF_DQREF_RST
		&& st.train == `DMRF_TRAIN_RST)
		else $error("defaults not loaded at reset");

	COV_CBT_ECHO: cover property (cbt_mode && !cke ##1 cke ##1 cmd.mrw);
	COV_FSP1_WRITE: cover property (st.train.write_read_setpoint_bit && cmd.mrw && cmd.addr == `DMRF_MA_DQREF);
	COV_RRO_SUB: cover property (feature_rro && !st.train.refresh_rate_option_bit && temp_raw == `DMRF_REF_CODE_B);
	COV_VREF_OUT: cover property (st.dq_src == DMRF_DQ_VREF && operating_setpoint_bit);
endmodule

// ==== tb/dmrf_ctrl_model.sv ====
// Memory controller model issuing mode register commands
module dmrf_ctrl_model
	import dmrf_pkg::*;
(
	input  wire logic core_clk,
	output dmrf_cmd_s cmd,
	output logic      cke
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd = '0;
		cke = 1'b1;
	end
	// Only plain writes and reads exist, so no masked write is ever sent;
	// the operand always carries range and level together
	task automatic send(input logic rd, input logic [5:0] a, input logic [7:0] d);
		@(negedge core_clk);
		cmd <= '{mrw: !rd, mrr: rd, addr: a, op: d};
		@(negedge core_clk);
		cmd <= '0;
	endtask
	task automatic set_cke(input logic v);
		@(negedge core_clk);
		cke <= v;
	endtask
endmodule

// ==== tb/dmrf_top_tb.sv ====
// Self-checking bench for the mode register group
module dmrf_top_tb
	import dmrf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, rst, cke, feature_rro, cal_req, cal_dmi_in;
	logic        dq_oe, cbt_mode, preamble_training, vref_fast;
	logic        data_mask_disabled, operating_setpoint_bit;
	logic [5:0]  ca;
	logic [6:0]  ca_ref_fsp0, ca_ref_fsp1, active_dq_ref;
	logic [2:0]  temp_raw, temp_report;
	logic [7:0]  cal_pattern;
	logic [15:0] dq_out;
	dmrf_cmd_s   cmd;
	dmrf_cal_s   cal_out;
	int          failures;
	int          num_checks;
	// Row: op, feature bit, raw code, expected {operating_setpoint_bit,dmd,reference_current_bit,rpt}, expected report
	logic [23:0] rows [8] = '{24'h021113, 24'h081223, 24'h201444, 24'h800181,
		24'haa02f2, 24'h101101, 24'h101202, 24'h001203};
	dmrf_ctrl_model m (.core_clk, .cmd, .cke);
	dmrf_top dut_u (.core_clk, .rst, .cmd, .cke, .ca, .ca_ref_fsp0, .ca_ref_fsp1,
		.feature_rro, .temp_raw, .cal_req, .cal_pattern, .cal_dmi_in, .dq_out, .dq_oe,
		.cal_out, .cbt_mode, .preamble_training, .vref_fast, .data_mask_disabled,
		.operating_setpoint_bit, .active_dq_ref, .temp_report);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		if (failures == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic w(input logic [5:0] a, input logic [7:0] d);
		m.send(1'b0, a, d);
	endtask
	// Read data stands for the one cycle that follows the taking edge
	task automatic r(input logic [5:0] a, input logic [15:0] exp);
		m.send(1'b1, a, 8'h00);
		chk(dq_out, exp);
		chk(dq_oe, 1'b1);
	endtask
	task automatic cal(input logic [7:0] p, input logic d, input logic [9:0] exp);
		@(negedge core_clk);
		{cal_req, cal_pattern, cal_dmi_in} = {1'b1, p, d};
		@(negedge core_clk);
		cal_req = 1'b0;
		chk(cal_out, exp);
	endtask
	initial begin
		#200000;
		failures++;
		results();
	end
	initial begin
		{rst, feature_rro, temp_raw, cal_req, cal_pattern, cal_dmi_in} = '0;
		rst = 1'b1;
		ca = 6'h2a;
		ca_ref_fsp0 = 7'h11;
		ca_ref_fsp1 = 7'h22;
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		chk({active_dq_ref, cbt_mode, preamble_training, vref_fast}, 16'h0268);
		chk({data_mask_disabled, operating_setpoint_bit, dq_oe}, 16'h0000);
		r(6'h0e, 16'h004d);
		foreach (rows[i]) begin
			w(6'h0d, rows[i][23:16]);
			feature_rro = rows[i][12];
			temp_raw = rows[i][10:8];
			@(negedge core_clk);
			chk({operating_setpoint_bit, data_mask_disabled, vref_fast, preamble_training},
				rows[i][7:4]);
			chk(temp_report, rows[i][2:0]);
		end
		r(6'h0d, 16'h0000);
		@(negedge core_clk);
		chk(dq_oe, 1'b0);
		chk(dq_out, 16'h0000);
		// Write set point 1 while operating from set point 0
		w(6'h0d, 8'h40);
		w(6'h0e, 8'h12);
		chk(active_dq_ref, 7'h4d);
		r(6'h0e, 16'h0012);
		w(6'h0e, 8'h33);
		r(6'h0e, 16'h0012);
		w(6'h0e, 8'h32);
		r(6'h0e, 16'h0032);
		w(6'h0d, 8'h00);
		r(6'h0e, 16'h004d);
		w(6'h0d, 8'h80);
		chk(active_dq_ref, 7'h32);
		w(6'h0d, 8'h84);
		@(negedge core_clk);
		chk(dq_out, 16'h2232);
		chk(dq_oe, 1'b1);
		w(6'h0d, 8'h01);
		chk(cbt_mode, 1'b1);
		m.set_cke(1'b0);
		@(negedge core_clk);
		chk(dq_out, 16'h002a);
		// Must be ignored while training with the clock enable low
		w(6'h0e, 8'h10);
		m.set_cke(1'b1);
		w(6'h0d, 8'h00);
		chk(cbt_mode, 1'b0);
		r(6'h0e, 16'h004d);
		cal(8'hff, 1'b1, 10'h355);
		w(6'h0f, 8'h15);
		cal(8'h00, 1'b0, 10'h22a);
		// Mid-run reset must restore both set point copies and the invert mask
		w(6'h0d, 8'h40);
		w(6'h0e, 8'h05);
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		chk({active_dq_ref, operating_setpoint_bit, cbt_mode, dq_oe, temp_report}, 16'h1340);
		w(6'h0d, 8'h40);
		r(6'h0e, 16'h004d);
		cal(8'h00, 1'b0, 10'h2aa);
		results();
	end
endmodule
